// ### srm_regs.svh
// register offsets, field positions, reset values and timing figures of the sysref monitor
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH

// ------------------------------------------------------------
// serial frame layout
// ------------------------------------------------------------
`define SRM_FRAME_BITS 5'h18
`define SRM_HDR_BITS 5'h10
`define SRM_LAST_BIT 5'h17
`define SRM_RW_BIT 15
`define SRM_ADDR_HI 11
`define SRM_ADDR_LO 0

// ------------------------------------------------------------
// pages and register offsets
// ------------------------------------------------------------
`define SRM_PAGE_ADDR 12'h005
`define SRM_PAGE_DIGITAL 8'h02
`define SRM_PAGE_ANALOG 8'h40
`define SRM_COUPLING_ADDR 12'h0b4
`define SRM_FLAGS_ADDR 12'h22f
`define SRM_ENCNT_ADDR 12'h236

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define SRM_COUPLING_AC 8'h01
`define SRM_ENCNT_INPUT_BIT 1
`define SRM_ENCNT_START_BIT 0
`define SRM_FLAGS_FIXED 1'h1
`define SRM_PAGE_RESET 8'h00
`define SRM_COUPLING_RESET 8'h00
`define SRM_ENCNT_RESET 8'h00
`define SRM_PULSE_LIMIT 16

// ------------------------------------------------------------
// capture window taps (index into the sampled tap vector)
// ------------------------------------------------------------
`define SRM_MAIN_DELAY_PS 160
`define SRM_TAP_COUNT 6
`define SRM_TAP_MAIN 2
`define SRM_TAP_M50_PS -50
`define SRM_TAP_M25_PS -25
`define SRM_TAP_P16_PS 16
`define SRM_TAP_P32_PS 32
`define SRM_TAP_P48_PS 48
`define SRM_WINDOW_PS 100

// ------------------------------------------------------------
// multiframe divisors for the bypass modes
// ------------------------------------------------------------
`define SRM_BYP_A_DIV 16'h0014
`define SRM_BYP_B_DIV 16'h0004

`endif

// ### srm_pkg.sv
// types shared by the sysref monitor files
package srm_pkg;

  // ------------------------------------------------------------
  // multiframe clock modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SRM_MODE_BYP_84810 = 2'h0,
    SRM_MODE_BYP_8422 = 2'h1,
    SRM_MODE_DECIM = 2'h2
  } srm_mode_type;

  // multiframe configuration carried as one port
  typedef struct packed {
    srm_mode_type mode;  // bypass or decimation
    logic [4:0] k;       // frames per multiframe
    logic [7:0] d;       // decimation factor
    logic [2:0] s;       // samples per frame
  } srm_lmfc_cfg_type;

  // ------------------------------------------------------------
  // serial port states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SRM_SPI_IDLE = 2'h0,
    SRM_SPI_SHIFT = 2'h1,
    SRM_SPI_READ = 2'h2
  } srm_spi_state_type;

endpackage : srm_pkg

// ### srm_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module srm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // first stage, read only by second

  initial begin
    if (WIDTH < 1) $error("srm_sync: WIDTH must be positive");
  end

  // ------------------------------------------------------------
  // two stages per bit
  // ------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        meta_q[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule : srm_sync

// ### srm_monitor.sv
// sysref capture, pulse counting, multiframe alignment, window monitor and paged serial port
`timescale 1ns/1ns
`include "srm_regs.svh"

// Operation
// - accepted sysref resets blocks, realigns multiframe
// - mask sends sysref only to oscillator
// - multiframe period 20K, 4K or DSK
// - count pulses, ignore after first sixteen
// - coupling register 0x01 selects AC coupling
// - main capture uses clock delayed 160 ps
// - extra samples at five offsets around capture
// - adjacent sample mismatch sets window flag
// - window flags refresh on each rising edge
// - flag register layout with fixed ones
module srm_monitor #(
  parameter int PULSE_LIMIT = `SRM_PULSE_LIMIT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic spi_sen_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  input wire logic [`SRM_TAP_COUNT-1:0] sysref_taps,
  input wire logic sysref_nco_only,
  input wire srm_pkg::srm_lmfc_cfg_type lmfc_cfg,
  output logic digital_reset_pulse,
  output logic nco_sync_pulse,
  output logic lmfc_pulse,
  output logic sysref_ac_coupled,
  output logic window_any_mismatch,
  output logic [4:0] sysref_pulse_count
);

  initial begin
    if (PULSE_LIMIT < 1 || PULSE_LIMIT > 31) $error("srm_monitor: PULSE_LIMIT out of range");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic sen_sel_s;  // synchronised select, high while selected
  logic sen_n_s;  // synchronised select, active low
  logic sclk_s;  // synchronised serial clock
  logic sdio_s;  // synchronised serial data
  logic [`SRM_TAP_COUNT-1:0] taps_s;  // synchronised window taps

  // taps arrive already captured by delayed clocks
  srm_sync #(.WIDTH(`SRM_TAP_COUNT + 3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({~spi_sen_n, spi_sclk, spi_sdio_in, sysref_taps}),
    .sync_out({sen_sel_s, sclk_s, sdio_s, taps_s})
  );

  // flops reset low, so the inverted select idles deselected after reset
  assign sen_n_s = ~sen_sel_s;

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  logic sclk_prev_q;  // previous serial clock
  logic main_prev_q;  // previous main capture
  logic sclk_rise;
  logic sclk_fall;
  logic main_rise;  // rising sysref on main capture

  // previous values for edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_q <= 1'b0;
      main_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      main_prev_q <= taps_s[`SRM_TAP_MAIN];
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q & ~sen_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~sen_n_s;
  assign main_rise = taps_s[`SRM_TAP_MAIN] & ~main_prev_q;

  // ------------------------------------------------------------
  // register decode helpers
  // ------------------------------------------------------------
  // paged address hit; the page register itself is unpaged
  function automatic logic reg_hit(input logic [7:0] page, input logic [11:0] addr,
                                   input logic [7:0] want_page, input logic [11:0] want_addr);
    reg_hit = (page == want_page) && (addr == want_addr);
  endfunction : reg_hit

  // multiframe length in sample periods
  function automatic logic [15:0] lmfc_len(input srm_pkg::srm_lmfc_cfg_type c);
    case (c.mode)
      srm_pkg::SRM_MODE_BYP_84810: lmfc_len = 16'(`SRM_BYP_A_DIV * {11'h000, c.k});
      srm_pkg::SRM_MODE_BYP_8422: lmfc_len = 16'(`SRM_BYP_B_DIV * {11'h000, c.k});
      srm_pkg::SRM_MODE_DECIM: lmfc_len = 16'({8'h00, c.d} * {13'h0000, c.s} * {11'h000, c.k});
      default: lmfc_len = 16'h0001;
    endcase
  endfunction : lmfc_len

  // ------------------------------------------------------------
  // serial port shift logic
  // ------------------------------------------------------------
  srm_pkg::srm_spi_state_type spi_state_q;  // frame phase
  logic [23:0] shift_q;  // incoming frame bits
  logic [23:0] shift_d;
  logic [4:0] bitcnt_q;  // bits taken this frame
  logic [7:0] rdata_q;  // read data being shifted out
  logic [7:0] page_q;  // page select
  logic [7:0] coupling_q;  // coupling select
  logic [7:0] encnt_q;  // enable and counter control
  logic [7:0] flags_rd;  // window flag register image
  logic [7:0] rd_mux;
  logic wr_commit;  // frame completes as a write
  logic [11:0] wr_addr;
  logic [7:0] wr_data;

  assign shift_d = {shift_q[22:0], sdio_s};
  assign wr_addr = shift_d[`SRM_ADDR_HI + 8:`SRM_ADDR_LO + 8];
  assign wr_data = shift_d[7:0];
  assign wr_commit = sclk_rise && (bitcnt_q == `SRM_LAST_BIT) && !shift_d[`SRM_RW_BIT + 8];

  // read data selection at the end of the header
  always_comb begin
    rd_mux = 8'h00;
    if (shift_d[`SRM_ADDR_HI:`SRM_ADDR_LO] == `SRM_PAGE_ADDR) begin
      rd_mux = page_q;
    end else if (reg_hit(page_q, shift_d[11:0], `SRM_PAGE_ANALOG, `SRM_COUPLING_ADDR)) begin
      rd_mux = coupling_q;
    end else if (reg_hit(page_q, shift_d[11:0], `SRM_PAGE_DIGITAL, `SRM_FLAGS_ADDR)) begin
      rd_mux = flags_rd;
    end else if (reg_hit(page_q, shift_d[11:0], `SRM_PAGE_DIGITAL, `SRM_ENCNT_ADDR)) begin
      rd_mux = encnt_q;
    end
  end

  // frame sequencing and read output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spi_state_q <= srm_pkg::SRM_SPI_IDLE;
      shift_q <= 24'h000000;
      bitcnt_q <= 5'h00;
      rdata_q <= 8'h00;
      spi_sdio_out <= 1'b0;
      spi_sdio_oe <= 1'b0;
    end else if (sen_n_s) begin
      // deselect aborts any frame
      spi_state_q <= srm_pkg::SRM_SPI_IDLE;
      bitcnt_q <= 5'h00;
      spi_sdio_oe <= 1'b0;
    end else begin
      case (spi_state_q)
        srm_pkg::SRM_SPI_IDLE: begin
          spi_state_q <= srm_pkg::SRM_SPI_SHIFT;
        end
        srm_pkg::SRM_SPI_SHIFT: begin
          if (sclk_rise) begin
            shift_q <= shift_d;
            bitcnt_q <= bitcnt_q + 5'h01;
            // header done: read frames switch to driving data
            if (bitcnt_q == `SRM_HDR_BITS - 5'h01 && shift_d[`SRM_RW_BIT]) begin
              rdata_q <= rd_mux;
              spi_state_q <= srm_pkg::SRM_SPI_READ;
            end
          end
        end
        srm_pkg::SRM_SPI_READ: begin
          if (sclk_fall && bitcnt_q < `SRM_FRAME_BITS) begin
            spi_sdio_oe <= 1'b1;
            spi_sdio_out <= rdata_q[7];
            rdata_q <= {rdata_q[6:0], 1'b0};
          end
          if (sclk_rise) begin
            bitcnt_q <= bitcnt_q + 5'h01;
          end
        end
        default: begin
          spi_state_q <= srm_pkg::SRM_SPI_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------
  logic hit_coupling;
  logic hit_encnt;

  assign hit_coupling = wr_commit
                        && reg_hit(page_q, wr_addr, `SRM_PAGE_ANALOG, `SRM_COUPLING_ADDR);
  assign hit_encnt = wr_commit && reg_hit(page_q, wr_addr, `SRM_PAGE_DIGITAL, `SRM_ENCNT_ADDR);

  // page, coupling and counter control storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_q <= `SRM_PAGE_RESET;
      coupling_q <= `SRM_COUPLING_RESET;
      encnt_q <= `SRM_ENCNT_RESET;
    end else begin
      if (wr_commit && wr_addr == `SRM_PAGE_ADDR) begin
        page_q <= wr_data;
      end
      if (hit_coupling) begin
        coupling_q <= wr_data;
      end
      if (hit_encnt) begin
        encnt_q <= wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sysref_ac_coupled <= 1'b0;
    end else begin
      sysref_ac_coupled <= (coupling_q == `SRM_COUPLING_AC);
    end
  end

  // ------------------------------------------------------------
  // pulse counter and sysref distribution
  // ------------------------------------------------------------
  logic cnt_clear;  // write with start bit low clears count
  logic accept;  // sysref edge that is used

  // enable and start bits gate counting
  assign cnt_clear = hit_encnt && !wr_data[`SRM_ENCNT_START_BIT];
  // only the first pulses after enabling count
  assign accept = main_rise && encnt_q[`SRM_ENCNT_INPUT_BIT] && encnt_q[`SRM_ENCNT_START_BIT]
                  && (sysref_pulse_count < 5'(PULSE_LIMIT));

  // count of accepted pulses; a clear wins, and a pulse in the same cycle restarts the count at one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sysref_pulse_count <= 5'h00;
    end else if (cnt_clear) begin
      sysref_pulse_count <= accept ? 5'h01 : 5'h00;
    end else if (accept) begin
      sysref_pulse_count <= sysref_pulse_count + 5'h01;
    end
  end

  // masked sysref reaches only the oscillator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      digital_reset_pulse <= 1'b0;
      nco_sync_pulse <= 1'b0;
    end else begin
      digital_reset_pulse <= accept && !sysref_nco_only;
      nco_sync_pulse <= accept;
    end
  end

  // ------------------------------------------------------------
  // local multiframe counter
  // ------------------------------------------------------------
  logic [15:0] period_q;  // multiframe length
  logic [15:0] period_d;  // coming multiframe length
  logic [15:0] lmfc_cnt_q;  // position within multiframe
  logic lmfc_wrap;

  // period from mode, K, D and S
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_q <= 16'h0001;
    end else begin
      period_q <= period_d;
    end
  end

  // zero length would never wrap, so it is held at one
  assign period_d = (lmfc_len(lmfc_cfg) == 16'h0000) ? 16'h0001 : lmfc_len(lmfc_cfg);
  // wrap against the coming length so a shortened period never overruns
  assign lmfc_wrap = (lmfc_cnt_q >= period_d - 16'h0001);

  // accepted unmasked sysref realigns the multiframe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lmfc_cnt_q <= 16'h0000;
      lmfc_pulse <= 1'b0;
    end else if (accept && !sysref_nco_only) begin
      lmfc_cnt_q <= 16'h0000;
      lmfc_pulse <= 1'b1;
    end else begin
      lmfc_cnt_q <= lmfc_wrap ? 16'h0000 : lmfc_cnt_q + 16'h0001;
      lmfc_pulse <= lmfc_wrap;
    end
  end

  // ------------------------------------------------------------
  // capture window monitor
  // ------------------------------------------------------------
  logic [4:0] mismatch;  // adjacent tap differences
  logic [4:0] flags_q;  // flags five down to one

  // five adjacent pairs across the tap vector
  // a differing pair marks the transition
  for (genvar i = 0; i < 5; i++) begin : g_pair
    assign mismatch[i] = taps_s[i] ^ taps_s[i + 1];
  end

  // refreshed on each rising edge, never sticky
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= 5'h00;
      window_any_mismatch <= 1'b0;
    end else if (main_rise) begin
      flags_q <= mismatch;
      window_any_mismatch <= |mismatch;
    end
  end

  // fixed ones around flags and combined bit
  assign flags_rd = {`SRM_FLAGS_FIXED, flags_q[4:0], window_any_mismatch, `SRM_FLAGS_FIXED};

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_accept_unmasked;
    accept && !sysref_nco_only;
  endsequence

  sequence s_realigned;
    digital_reset_pulse && lmfc_pulse && lmfc_cnt_q == 16'h0000;
  endsequence

  a_lmfc_realign: assert property (s_accept_unmasked |=> s_realigned)
    else $error("multiframe not realigned by sysref");
  a_mask_nco_only: assert property (accept && sysref_nco_only |=> nco_sync_pulse
                                    && !digital_reset_pulse)
    else $error("masked sysref reached digital blocks");
  a_lmfc_period: assert property (lmfc_cnt_q < period_q)
    else $error("multiframe counter beyond period");
  a_pulse_ignore: assert property (sysref_pulse_count == 5'(PULSE_LIMIT) && !cnt_clear
                                   |=> !nco_sync_pulse)
    else $error("sysref used after pulse limit");
  a_coupling_sel: assert property (hit_coupling |=> ##1 sysref_ac_coupled ==
                                   ($past(wr_data, 2) == `SRM_COUPLING_AC))
    else $error("coupling output does not follow register");
  a_flags_update: assert property (main_rise |=> flags_q
                                   == $past(taps_s[4:0] ^ taps_s[5:1]))
    else $error("window flags not loaded");
  a_flags_hold: assert property (!main_rise |=> $stable(flags_q))
    else $error("window flags changed without sysref edge");
  a_flag_layout: assert property (flags_rd[7] && flags_rd[0]
                                  && flags_rd[6:2] == flags_q)
    else $error("flag register layout wrong");
  a_flag_or: assert property (main_rise ##1 1'b1 |-> window_any_mismatch == |flags_q)
    else $error("combined flag is not OR of flags");

endmodule : srm_monitor

// ### srm_sysref_gen.sv
// sysref source model driving the six window tap samples of the monitor
`timescale 1ns/1ns
module srm_sysref_gen (
  input wire logic clk,
  output logic [5:0] sysref_taps
);
  // ------------------------------------------------------------
  // idle level
  // ------------------------------------------------------------
  // sysref rests low between pulses
  initial sysref_taps = 6'h00;

  // ------------------------------------------------------------
  // pulse generation
  // ------------------------------------------------------------
  // edge on clock rise, taps early to late
  task automatic send(input logic [5:0] pat, input int hold, input int gap);
    @(posedge clk);
    sysref_taps <= pat;
    repeat (hold) @(posedge clk);
    sysref_taps <= 6'h00;
    repeat (gap) @(posedge clk);
    // hand back off the edge so callers drive on the falling edge
    @(negedge clk);
  endtask : send

  // periodic train, period a multiple of lmfc
  task automatic train(input int count, input int period);
    repeat (count) send(6'h3f, 4, period - 5);
  endtask : train
endmodule : srm_sysref_gen

// ### srm_monitor_test.sv
// self-checking bench for the sysref monitor
`timescale 1ns/1ns
`include "srm_regs.svh"
module srm_monitor_test;
  logic clk;  // 25 MHz clock
  logic resetn;  // active-low reset
  logic spi_sen_n;  // serial select, active low
  logic spi_sclk;  // serial clock
  logic sdio_drv;  // bench value onto sdio
  logic sdio_en;  // bench drives sdio
  logic sdio_line;  // resolved sdio wire
  logic spi_sdio_out;
  logic spi_sdio_oe;
  logic [5:0] sysref_taps;
  logic sysref_nco_only;
  srm_pkg::srm_lmfc_cfg_type lmfc_cfg;
  logic digital_reset_pulse;
  logic nco_sync_pulse;
  logic lmfc_pulse;
  logic sysref_ac_coupled;
  logic window_any_mismatch;
  logic [4:0] sysref_pulse_count;
  int error_cnt = 0;
  int check_count = 0;
  int rst_seen = 0;  // digital reset pulses seen
  int nco_seen = 0;  // oscillator sync pulses seen

  // sdio has a pull-down; device drives when enabled
  assign sdio_line = spi_sdio_oe ? spi_sdio_out : (sdio_en ? sdio_drv : 1'b0);

  srm_monitor dut (.clk(clk), .resetn(resetn), .spi_sen_n(spi_sen_n), .spi_sclk(spi_sclk),
    .spi_sdio_in(sdio_line), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
    .sysref_taps(sysref_taps), .sysref_nco_only(sysref_nco_only), .lmfc_cfg(lmfc_cfg),
    .digital_reset_pulse(digital_reset_pulse), .nco_sync_pulse(nco_sync_pulse),
    .lmfc_pulse(lmfc_pulse), .sysref_ac_coupled(sysref_ac_coupled),
    .window_any_mismatch(window_any_mismatch), .sysref_pulse_count(sysref_pulse_count));

  srm_sysref_gen gen (.clk(clk), .sysref_taps(sysref_taps));

  // ------------------------------------------------------------
  // clock and pulse counters
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // one-cycle pulses seen once each at the falling edge
  always @(negedge clk) begin
    if (digital_reset_pulse === 1'b1) rst_seen++;
    if (nco_sync_pulse === 1'b1) nco_seen++;
  end

  // ------------------------------------------------------------
  // compare and bus tasks
  // ------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask : check1

  // one 24-bit frame, six clocks per sclk level
  task automatic spi(input logic rw, input logic [11:0] addr, input logic [7:0] wd,
                     output logic [7:0] rdat);
    logic [23:0] fr;
    fr = {rw, 3'h0, addr, wd};
    rdat = 8'h00;
    spi_sen_n = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      spi_sclk = 1'b0;
      sdio_en = !(rw && i < 8);
      sdio_drv = fr[i];
      repeat (6) @(negedge clk);
      if (rw && i < 8) rdat[i] = sdio_line;
      spi_sclk = 1'b1;
      repeat (6) @(negedge clk);
    end
    spi_sclk = 1'b0;
    repeat (6) @(negedge clk);
    spi_sen_n = 1'b1;
    sdio_en = 1'b0;
    repeat (6) @(negedge clk);
  endtask : spi

  task automatic wr(input logic [11:0] addr, input logic [7:0] wd);
    logic [7:0] unused;
    spi(1'b0, addr, wd, unused);
  endtask : wr

  task automatic rdchk(input logic [11:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    spi(1'b1, addr, 8'h00, v);
    check8(v, exp);
  endtask : rdchk

  // expected flag register from a tap pattern
  function automatic logic [7:0] flag_byte(input logic [5:0] p);
    logic [4:0] f;
    f = p[4:0] ^ p[5:1];
    return {1'b1, f, |f, 1'b1};
  endfunction : flag_byte

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_regs();
    wr(`SRM_PAGE_ADDR, `SRM_PAGE_ANALOG);
    rdchk(`SRM_COUPLING_ADDR, 8'h00);
    wr(`SRM_COUPLING_ADDR, `SRM_COUPLING_AC);
    rdchk(`SRM_COUPLING_ADDR, 8'h01);
    check1(sysref_ac_coupled, 1'b1);
    wr(`SRM_COUPLING_ADDR, 8'h03);
    check1(sysref_ac_coupled, 1'b0);
    wr(`SRM_PAGE_ADDR, `SRM_PAGE_DIGITAL);
    wr(`SRM_COUPLING_ADDR, 8'h01);
    check1(sysref_ac_coupled, 1'b0);
    rdchk(`SRM_FLAGS_ADDR, 8'h81);
    rdchk(`SRM_ENCNT_ADDR, 8'h00);
    rdchk(12'h123, 8'h00);
    $display("test registers done");
  endtask : test_regs

  task automatic test_window();
    logic [5:0] pats [6] = '{6'h3c, 6'h3e, 6'h07, 6'h0f, 6'h1f, 6'h3f};
    foreach (pats[i]) begin
      gen.send(pats[i], 4, 4);
      check1(window_any_mismatch, |(pats[i][4:0] ^ pats[i][5:1]));
      rdchk(`SRM_FLAGS_ADDR, flag_byte(pats[i]));
    end
    $display("test window done");
  endtask : test_window

  task automatic test_count();
    int r0;
    int n0;
    r0 = rst_seen;
    n0 = nco_seen;
    gen.send(6'h3f, 4, 4);
    check8(8'(rst_seen - r0), 8'h00);
    wr(`SRM_ENCNT_ADDR, 8'h02);
    wr(`SRM_ENCNT_ADDR, 8'h03);
    gen.send(6'h3b, 4, 4);
    check8(8'(rst_seen - r0), 8'h00);
    gen.train(17, 40);
    check8(8'(rst_seen - r0), 8'h10);
    check8(8'(nco_seen - n0), 8'h10);
    check8({3'h0, sysref_pulse_count}, 8'h10);
    wr(`SRM_ENCNT_ADDR, 8'h02);
    check8({3'h0, sysref_pulse_count}, 8'h00);
    wr(`SRM_ENCNT_ADDR, 8'h03);
    sysref_nco_only = 1'b1;
    gen.send(6'h3f, 4, 4);
    check8(8'(rst_seen - r0), 8'h10);
    check8(8'(nco_seen - n0), 8'h11);
    sysref_nco_only = 1'b0;
    $display("test count done");
  endtask : test_count

  task automatic lmfc_run(input srm_pkg::srm_lmfc_cfg_type cfg, input int exp);
    int n;
    lmfc_cfg = cfg;
    wr(`SRM_ENCNT_ADDR, 8'h02);
    wr(`SRM_ENCNT_ADDR, 8'h03);
    fork
      gen.send(6'h3f, 4, 4);
    join_none
    n = 0;
    while (digital_reset_pulse !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check1(lmfc_pulse, 1'b1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lmfc_pulse !== 1'b1 && n < 3000);
    check8(8'(n), 8'(exp));
  endtask : lmfc_run

  task automatic test_lmfc();
    lmfc_run('{srm_pkg::SRM_MODE_BYP_84810, 5'h03, 8'h01, 3'h1}, 60);
    lmfc_run('{srm_pkg::SRM_MODE_BYP_8422, 5'h05, 8'h01, 3'h1}, 20);
    lmfc_run('{srm_pkg::SRM_MODE_DECIM, 5'h03, 8'h04, 3'h2}, 24);
    $display("test lmfc done");
  endtask : test_lmfc

  // ------------------------------------------------------------
  // verdict, main sequence and watchdog
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    resetn = 1'b0;
    spi_sen_n = 1'b1;
    spi_sclk = 1'b0;
    sdio_drv = 1'b0;
    sdio_en = 1'b0;
    sysref_nco_only = 1'b0;
    lmfc_cfg = '{srm_pkg::SRM_MODE_BYP_84810, 5'h01, 8'h01, 3'h1};
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    test_regs();
    test_window();
    test_count();
    test_lmfc();
    complete_run();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    complete_run();
  end
endmodule : srm_monitor_test
